//--- design/sbw_pkg.sv
// shared constants and types for the single bit two-wire bus interface
package sbw_pkg;

    // ==================================================================
    // register map
    localparam logic [7:0] ADDR_CTRL = 8'hd8;
    localparam logic [7:0] ADDR_DATA = 8'hd9;
    localparam logic [7:0] ADDR_CFG = 8'hdc;
    localparam logic [7:0] CTRL_RESET = 8'h81;
    localparam logic [7:0] CFG_RESET = 8'h00;

    // ==================================================================
    // bus_control_status bit positions (read meaning / write meaning)
    localparam int B_RBIT = 7;   // received_bit / clear_transmit_active
    localparam int B_ATN = 6;    // attention_flag / slave idle
    localparam int B_BIT_READY_FLAG = 5;   // bit_ready_flag / clear_bit_ready
    localparam int B_ARL = 4;    // arbitration_lost_flag / clear
    localparam int B_STR = 3;    // start_seen_flag / clear
    localparam int B_STP = 2;    // stop_seen_flag / clear
    localparam int B_MST = 1;    // master / send_repeated_start
    localparam int B_SEND_STOP = 0;   // undefined / send_stop

    // ==================================================================
    // bus_configuration bit positions
    localparam int C_PRE_LO = 0;   // timer_prescale_low
    localparam int C_PRE_HI = 1;   // timer_prescale_high
    localparam int C_BIE = 5;      // bus_interrupt_enable
    localparam int C_MRQ = 6;      // master_request
    localparam int C_EN = 7;       // interface enable

    // ==================================================================
    // bus timer
    localparam int TMR_W = 10;
    localparam logic [2:0] SPAN_END = 3'h7;
    localparam logic [9:0] TMR_MAX = 10'h3ff;
    localparam logic [9:0] TMR_PRE0 = 10'h000;
    localparam logic [9:0] TMR_PRE1 = 10'h001;
    localparam logic [9:0] TMR_PRE2 = 10'h002;
    localparam logic [9:0] TMR_PRE3 = 10'h003;

    // master sequencer states
    typedef enum logic [2:0] {
        M_IDLE,
        M_FREE,
        M_START,
        M_LOW,
        M_HIGH,
        M_RSTART,
        M_STOP
    } sbw_mst_t;

endpackage

//--- design/sbw_bus_timer.sv
// ten bit bus timer: span ticks and clock-change watchdog
`timescale 1ns/100ps
`default_nettype none
module sbw_bus_timer
    import sbw_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic run_i,
    input wire logic restart_i,
    input wire logic [1:0] sel_i,
    output logic span_ok_o,
    output logic carry_o
);

    logic [TMR_W-1:0] cnt_q;
    logic [TMR_W-1:0] pre;

    // ==================================================================
    // preload select, lets slow oscillators shorten the spans
    always_comb begin
        unique case (sel_i)
            2'h0: pre = TMR_PRE0;
            2'h1: pre = TMR_PRE1;
            2'h2: pre = TMR_PRE2;
            2'h3: pre = TMR_PRE3;
        endcase
    end

    // counter holds at preload while stopped, saturates at the top
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= TMR_PRE0;
        end else if (!run_i || restart_i) begin
            cnt_q <= pre;
        end else if (cnt_q != TMR_MAX) begin
            cnt_q <= cnt_q + 10'h001;
        end
    end

    // low three bits time the short spans, all ten the watchdog
    assign span_ok_o = (cnt_q[9:3] != 7'h00) || (cnt_q[2:0] == SPAN_END);
    assign carry_o = run_i && (cnt_q == TMR_MAX);

endmodule
`default_nettype wire

//--- design/sbw_core.sv
// single bit two-wire bus interface: registers, flags, master sequencer
// ==================================================================
// Behaviour
// - low timer bits time six minimum spans
// - master clock low held until minimum met
// - clock low stretched until software responds
// - timer preload picked by two prescale bits
// - timer clears on every clock line edge
// - timer stopped between frames while the master sequencer is idle
// - carry after 1020 to 1023 idle cycles
// - carry resets interface and frees clock
// - interrupt on attention when both enables set
// - bit7 reads received bit, write clears active
// - bit6 reads attention, any flag set
// - bit6 write makes slave ignore bus
// - bit5 bit ready on clock rise, cleared
// - bit4 arbitration lost flag, write clears
// - bit3 start seen flag, write clears
// - bit2 stop seen flag, write clears
// - bit1 reads master, write sends restart
// - bit0 write sends a stop condition
// - data line driven low while active with a zero bit outside free and stop, and in start and restart
// - any pending flag keeps clock stretched
// - master set when requested and bus free
`timescale 1ns/100ps
`default_nettype none
module sbw_core
    import sbw_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [7:0] reg_rdata_o,
    input wire logic global_irq_en_i,
    output logic irq_o,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_n_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o
);

    // ==================================================================
    // declarations
    logic [1:0] pin_s1_q;
    logic [1:0] pin_s2_q;
    logic [1:0] pin_p_q;
    logic scl, sda, scl_rise, scl_edge, start_det, stop_det;
    logic wr_ctl, wr_dat, rd_dat, wr_cfg;
    logic [7:0] cfg_q;
    logic [7:0] rdata_q;
    logic en, mrq;
    logic bit_ready_flag_q, arl_q, str_q, stp_q, attn;
    logic bit_ready_flag_set, arl_set, str_set, stp_set;
    logic rbit_q, xbit_q, txa_q;
    logic busy_q, idle_q, master_q;
    logic rst_pend_q, stop_pend_q;
    sbw_mst_t mst_q;
    sbw_mst_t mst_d;
    logic span_ok, tmr_carry, tmr_run, tmr_restart, soft_rst;
    logic scl_low_d, sda_low_d, scl_oe_n_q, sda_oe_n_q;
    logic stretch_q;

    // ==================================================================
    // pin synchronisers, bit 0 clock line, bit 1 data line
    for (genvar i = 0; i < 2; i++) begin : g_sync
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                pin_s1_q[i] <= 1'b1;
                pin_s2_q[i] <= 1'b1;
                pin_p_q[i] <= 1'b1;
            end else begin
                pin_s1_q[i] <= (i == 0) ? scl_i : sda_i;
                pin_s2_q[i] <= pin_s1_q[i];
                pin_p_q[i] <= pin_s2_q[i];
            end
        end
    end

    // edge and condition detect, only past the second stage
    assign scl = pin_s2_q[0];
    assign sda = pin_s2_q[1];
    assign scl_rise = scl && !pin_p_q[0];
    assign scl_edge = scl ^ pin_p_q[0];
    assign start_det = en && scl && pin_p_q[0] && !sda && pin_p_q[1];
    assign stop_det = en && scl && pin_p_q[0] && sda && !pin_p_q[1];

    // ==================================================================
    // register port decode
    assign wr_ctl = reg_we_i && (reg_addr_i == ADDR_CTRL);
    assign wr_dat = reg_we_i && (reg_addr_i == ADDR_DATA);
    assign wr_cfg = reg_we_i && (reg_addr_i == ADDR_CFG);
    assign rd_dat = reg_re_i && (reg_addr_i == ADDR_DATA);
    assign en = cfg_q[C_EN];
    assign mrq = cfg_q[C_MRQ];

    // configuration register, untouched by the watchdog reset
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_q <= CFG_RESET;
        end else if (wr_cfg) begin
            cfg_q <= reg_wdata_i;
        end
    end

    // ==================================================================
    // bus timer: clears on clock edges, runs only inside a frame or while the master sequencer is active
    assign tmr_run = en && (busy_q || mst_q != M_IDLE);
    assign tmr_restart = scl_edge || (mst_d != mst_q);
    assign soft_rst = tmr_carry;

    sbw_bus_timer u_timer (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .run_i(tmr_run),
        .restart_i(tmr_restart),
        .sel_i(cfg_q[C_PRE_HI:C_PRE_LO]),
        .span_ok_o(span_ok),
        .carry_o(tmr_carry)
    );

    // ==================================================================
    // status flags: a set in the clear cycle wins
    assign bit_ready_flag_set = en && scl_rise && (master_q || (busy_q && !idle_q));
    assign arl_set = en && scl_rise && txa_q && xbit_q && !sda;
    assign str_set = start_det && (master_q || !idle_q);
    assign stp_set = stop_det && (master_q || !idle_q);
    assign attn = bit_ready_flag_q || arl_q || str_q || stp_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bit_ready_flag_q <= 1'b0;
            arl_q <= 1'b0;
            str_q <= 1'b0;
            stp_q <= 1'b0;
        end else if (soft_rst) begin
            bit_ready_flag_q <= 1'b0;
            arl_q <= 1'b0;
            str_q <= 1'b0;
            stp_q <= 1'b0;
        end else begin
            // data register access also acknowledges the bit
            bit_ready_flag_q <= bit_ready_flag_set || (bit_ready_flag_q && !((wr_ctl && reg_wdata_i[B_BIT_READY_FLAG])
                      || wr_dat || rd_dat));
            arl_q <= arl_set || (arl_q && !(wr_ctl && reg_wdata_i[B_ARL]));
            str_q <= str_set || (str_q && !(wr_ctl && reg_wdata_i[B_STR]));
            stp_q <= stp_set || (stp_q && !(wr_ctl && reg_wdata_i[B_STP]));
        end
    end

    // received bit sampled on every clock rise
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rbit_q <= CTRL_RESET[B_RBIT];
        end else if (scl_rise) begin
            rbit_q <= sda;
        end
    end

    // ==================================================================
    // transmit bit and transmit-active state
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            xbit_q <= 1'b1;
        end else if (wr_ctl && reg_wdata_i[B_MST]) begin
            xbit_q <= 1'b1;
        end else if (wr_ctl && reg_wdata_i[B_SEND_STOP]) begin
            xbit_q <= 1'b0;
        end else if (wr_dat) begin
            xbit_q <= reg_wdata_i[7];
        end
    end

    // losing arbitration drops the active state outright
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            txa_q <= 1'b0;
        end else if (soft_rst || arl_set || arl_q) begin
            txa_q <= 1'b0;
        end else if (wr_dat || (wr_ctl && (reg_wdata_i[B_MST] || reg_wdata_i[B_SEND_STOP]))) begin
            txa_q <= 1'b1;
        end else if ((wr_ctl && reg_wdata_i[B_RBIT]) || rd_dat) begin
            txa_q <= 1'b0;
        end else if (mst_q == M_STOP && mst_d == M_IDLE) begin
            txa_q <= 1'b0; // a finished stop must not leave the data line pulled
        end
    end

    // pending restart and stop requests for the sequencer
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_pend_q <= 1'b0;
            stop_pend_q <= 1'b0;
        end else if (soft_rst || !master_q) begin
            rst_pend_q <= 1'b0;
            stop_pend_q <= 1'b0;
        end else begin
            if (wr_ctl && reg_wdata_i[B_MST]) begin
                rst_pend_q <= 1'b1;
            end else if (mst_q == M_RSTART && mst_d == M_LOW) begin
                rst_pend_q <= 1'b0;
            end
            if (wr_ctl && reg_wdata_i[B_SEND_STOP]) begin
                stop_pend_q <= 1'b1;
            end else if (mst_q == M_STOP && mst_d == M_IDLE) begin
                stop_pend_q <= 1'b0;
            end
        end
    end

    // ==================================================================
    // bus busy, slave idle and master indication
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy_q <= 1'b0;
        end else if (soft_rst || stop_det || !en) begin
            busy_q <= 1'b0;
        end else if (start_det) begin
            busy_q <= 1'b1;
        end
    end

    // idle slave wakes on the next start without raising a flag
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            idle_q <= 1'b1;
        end else if (soft_rst) begin
            idle_q <= 1'b1;
        end else if (start_det) begin
            idle_q <= 1'b0;
        end else if (wr_ctl && reg_wdata_i[B_ATN] && !master_q) begin
            idle_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            master_q <= 1'b0;
        end else if (soft_rst || arl_set) begin
            master_q <= 1'b0;
        end else if (mst_q == M_STOP && mst_d == M_IDLE && !mrq) begin
            master_q <= 1'b0;
        end else if (en && mrq && !busy_q) begin
            master_q <= 1'b1;
        end
    end

    // ==================================================================
    // master sequencer: free time, start, clock phases, restart, stop
    always_comb begin
        mst_d = mst_q;
        unique case (mst_q)
            M_IDLE: begin
                if (master_q && !busy_q) begin
                    mst_d = M_FREE;
                end
            end
            M_FREE: begin
                if (busy_q) begin
                    mst_d = M_IDLE;
                end else if (span_ok) begin
                    mst_d = M_START;
                end
            end
            M_START: begin
                if (span_ok) begin
                    mst_d = M_LOW;
                end
            end
            M_LOW: begin
                // early answers still wait out the low span
                if (span_ok && !attn) begin
                    mst_d = M_HIGH;
                end
            end
            M_HIGH: begin
                // a slave may stretch, so wait for the line itself
                if (scl && !scl_edge && span_ok) begin
                    if (rst_pend_q && sda) begin
                        mst_d = M_RSTART;
                    end else if (stop_pend_q) begin
                        mst_d = M_STOP;
                    end else begin
                        mst_d = M_LOW;
                    end
                end
            end
            M_RSTART: begin
                if (span_ok) begin
                    mst_d = M_LOW;
                end
            end
            M_STOP: begin
                if (span_ok) begin
                    mst_d = M_IDLE;
                end
            end
            default: mst_d = M_IDLE;
        endcase
        if (!master_q && mst_q != M_STOP) begin
            mst_d = M_IDLE;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mst_q <= M_IDLE;
        end else if (soft_rst) begin
            mst_q <= M_IDLE;
        end else begin
            mst_q <= mst_d;
        end
    end

    // ==================================================================
    // slave stretch: hold the low phase once seen while flags pend
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stretch_q <= 1'b0;
        end else if (soft_rst || !attn || master_q || idle_q || !en) begin
            stretch_q <= 1'b0;
        end else if (!scl) begin
            stretch_q <= 1'b1;
        end
    end

    // line drive decisions; both lines only ever pulled low
    assign scl_low_d = (mst_q == M_LOW) || stretch_q;
    assign sda_low_d = en && ((mst_q == M_START) || (mst_q == M_RSTART)
                       || (txa_q && !xbit_q && mst_q != M_STOP && mst_q != M_FREE));

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scl_oe_n_q <= 1'b1;
            sda_oe_n_q <= 1'b1;
        end else if (soft_rst) begin
            scl_oe_n_q <= 1'b1;
            sda_oe_n_q <= 1'b1;
        end else begin
            scl_oe_n_q <= !scl_low_d;
            sda_oe_n_q <= !sda_low_d;
        end
    end

    assign scl_oe_n_o = scl_oe_n_q;
    assign sda_oe_n_o = sda_oe_n_q;
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;

    // ==================================================================
    // read data, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q <= 8'h00;
        end else if (!reg_re_i) begin
            rdata_q <= 8'h00;
        end else if (reg_addr_i == ADDR_CTRL) begin
            // undefined bit 0 kept at its reset reading
            rdata_q <= {rbit_q, attn, bit_ready_flag_q, arl_q, str_q, stp_q, master_q,
                        CTRL_RESET[B_SEND_STOP]};
        end else if (reg_addr_i == ADDR_DATA) begin
            rdata_q <= {rbit_q, 7'h00};
        end else if (reg_addr_i == ADDR_CFG) begin
            rdata_q <= cfg_q;
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign reg_rdata_o = rdata_q;

    // interrupt needs both the global and the bus enable
    assign irq_o = attn && global_irq_en_i && cfg_q[C_BIE];

    // ==================================================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    scl_release_a: assert property (soft_rst |=> scl_oe_n_o)
        else $error("clock line held after watchdog reset");
    bit_ready_a: assert property (bit_ready_flag_set && !soft_rst |=> bit_ready_flag_q)
        else $error("bit ready not set on clock rise");
    attn_read_a: assert property (reg_re_i && reg_addr_i == ADDR_CTRL
        |=> reg_rdata_o[B_ATN] == ($past(bit_ready_flag_q) || $past(arl_q) || $past(str_q)
        || $past(stp_q)))
        else $error("attention read wrong");
    rbit_cap_a: assert property (scl_rise |=> rbit_q == $past(sda))
        else $error("received bit not captured");
    low_stretch_a: assert property (mst_q == M_LOW && attn && !soft_rst
        |=> mst_q == M_LOW)
        else $error("master clock released with flags pending");
    min_low_a: assert property (mst_q == M_LOW && !span_ok && !soft_rst
        |=> mst_q == M_LOW)
        else $error("master low phase cut short");
    arl_txa_a: assert property (arl_q |-> !txa_q)
        else $error("transmit active with arbitration lost");
    data_drive_a: assert property (!sda_oe_n_o && $past(mst_q) == M_LOW
        |-> $past(txa_q))
        else $error("data driven low while not active");
    start_flag_a: assert property (start_det && master_q && !soft_rst |=> str_q)
        else $error("start flag missed");
    timer_idle_a: assert property (!busy_q && mst_q == M_IDLE
        |=> !span_ok && !tmr_carry)
        else $error("timer ran between frames");
    master_set_a: assert property (en && mrq && !busy_q && !master_q && !soft_rst
        && !arl_set |=> master_q)
        else $error("master not taken on free bus");
    irq_a: assert property (irq_o == ((bit_ready_flag_q || arl_q || str_q || stp_q)
        && global_irq_en_i && cfg_q[C_BIE]))
        else $error("interrupt does not follow flags and enables");

    bit_ready_c: cover property (bit_ready_flag_set);
    arb_lost_c: cover property (arl_set);
    timeout_c: cover property (soft_rst);
    stop_sent_c: cover property (mst_q == M_STOP ##1 mst_q == M_IDLE);

endmodule
`default_nettype wire

//--- tb/sbw_bus_peer.sv
// behavioural model of another party on the two-wire bus
`timescale 1ns/100ps
`default_nettype none
module sbw_bus_peer (
    input wire logic clk_i,
    input wire logic scl_i,
    output logic scl_oe_n_o,
    output logic sda_oe_n_o,
    output logic stall_o
);
    // ==================================================================
    // open-drain drivers, released at time zero
    initial begin
        scl_oe_n_o = 1'b1;
        sda_oe_n_o = 1'b1;
        stall_o = 1'b0;
    end

    // ten cycles per half period, longer than any minimum span
    task automatic half();
        repeat (10) @(posedge clk_i);
    endtask

    // release the clock and wait, bounded, while the device stretches it
    task automatic rise();
        int n;
        scl_oe_n_o <= 1'b1;
        n = 0;
        @(posedge clk_i);
        while (scl_i !== 1'b1 && n < 3000) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 3000) begin
            stall_o <= 1'b1;
        end
    endtask

    task automatic start();
        sda_oe_n_o <= 1'b0;
        half();
        scl_oe_n_o <= 1'b0;
        half();
    endtask

    // data changes only while the clock is low
    task automatic send_bit(input logic b);
        sda_oe_n_o <= b;
        half();
        rise();
        half();
        scl_oe_n_o <= 1'b0;
        half();
    endtask

    task automatic rstart();
        sda_oe_n_o <= 1'b1;
        half();
        rise();
        half();
        sda_oe_n_o <= 1'b0;
        half();
        scl_oe_n_o <= 1'b0;
        half();
    endtask

    task automatic stop();
        sda_oe_n_o <= 1'b0;
        half();
        rise();
        half();
        sda_oe_n_o <= 1'b1;
        half();
    endtask
endmodule
`default_nettype wire

//--- tb/test_single_bit_two_wire_interface.sv
// self-checking bench for the single bit two-wire bus interface
`timescale 1ns/100ps
`default_nettype none
module test_single_bit_two_wire_interface;
    import sbw_pkg::*;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic reg_we_i = 1'b0;
    logic reg_re_i = 1'b0;
    logic gie = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic [7:0] reg_rdata_o;
    logic [7:0] v;
    logic irq_o, scl_o, sda_o, scl_oe_n_o, sda_oe_n_o, p_scl_n, p_sda_n, p_stall;
    int fails = 0;
    int samples_checked = 0;
    // ==================================================================
    // wired-and bus lines with pull-ups
    wire scl_w = scl_oe_n_o & p_scl_n;
    wire sda_w = sda_oe_n_o & p_sda_n;

    sbw_core u_sbw_core (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
        .reg_rdata_o(reg_rdata_o), .global_irq_en_i(gie), .irq_o(irq_o), .scl_i(scl_w),
        .scl_o(scl_o), .scl_oe_n_o(scl_oe_n_o), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe_n_o(sda_oe_n_o));
    sbw_bus_peer u_sbw_bus_peer (.clk_i(clk_i), .scl_i(scl_w), .scl_oe_n_o(p_scl_n),
        .sda_oe_n_o(p_sda_n), .stall_o(p_stall));

    initial begin
        forever #2 clk_i = ~clk_i;
    end

    // ==================================================================
    // shared helpers
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", n, e, g);
            fails++;
        end
    endtask

    // whole-byte writes only, never a single-bit modify
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_we_i <= 1'b1;
        @(posedge clk_i);
        reg_we_i <= 1'b0;
    endtask

    // data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_re_i <= 1'b1;
        @(posedge clk_i);
        reg_re_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask

    task automatic stop_test();
        chk("peer stall", 8'h00, {7'h0, p_stall});
        $display("compares %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // ==================================================================
    // scenarios
    task automatic t_reset();
        rd(ADDR_CTRL, v);
        chk("status after reset", 8'h81, v);
        rd(8'h00, v);
        chk("unmapped read", 8'h00, v);
        chk("line enables", 8'h03, {6'h0, scl_oe_n_o, sda_oe_n_o});
    endtask

    task automatic t_bit_zero();
        wr(ADDR_CFG, 8'ha0);
        u_sbw_bus_peer.start();
        rd(ADDR_CTRL, v);
        chk("no start at idle slave", 8'h81, v);
        u_sbw_bus_peer.send_bit(1'b0);
        rd(ADDR_CTRL, v);
        chk("bit ready, bit 0", 8'h61, v);
        chk("clock stretched", 8'h00, {7'h0, scl_oe_n_o});
        chk("irq masked", 8'h00, {7'h0, irq_o});
        @(posedge clk_i);
        gie <= 1'b1;
        @(posedge clk_i);
        #1 chk("irq raised", 8'h01, {7'h0, irq_o});
        wr(ADDR_CTRL, 8'h20);
        repeat (3) @(posedge clk_i);
        #1 chk("clock freed", 8'h01, {7'h0, scl_oe_n_o});
        chk("irq cleared", 8'h00, {7'h0, irq_o});
        @(posedge clk_i);
        gie <= 1'b0;
    endtask

    task automatic t_bit_one();
        u_sbw_bus_peer.send_bit(1'b1);
        rd(ADDR_CTRL, v);
        chk("bit ready, bit 1", 8'he1, v);
        rd(ADDR_DATA, v);
        chk("data read", 8'h80, v);
        rd(ADDR_CTRL, v);
        chk("ready cleared by data read", 8'h81, v);
    endtask

    task automatic t_frames();
        u_sbw_bus_peer.rstart();
        rd(ADDR_CTRL, v);
        chk("repeated start", 8'he9, v);
        wr(ADDR_CTRL, 8'h28);
        u_sbw_bus_peer.stop();
        rd(ADDR_CTRL, v);
        chk("stop seen", 8'h65, v);
        wr(ADDR_CTRL, 8'h24);
        rd(ADDR_CTRL, v);
        chk("flags cleared", 8'h01, v);
    endtask

    // own frame as master: start, held low phase, then stop with request dropped
    task automatic t_master();
        wr(ADDR_CFG, 8'hc0);
        repeat (30) @(posedge clk_i);
        rd(ADDR_CTRL, v);
        chk("master start", 8'h4b, v & 8'h7f);
        chk("master low phase", 8'h01, {6'h0, scl_oe_n_o, sda_oe_n_o});
        wr(ADDR_CFG, 8'h80);
        wr(ADDR_CTRL, 8'h09);
        @(posedge clk_i);
        #1 chk("stop data low", 8'h00, {7'h0, sda_oe_n_o});
        repeat (30) @(posedge clk_i);
        rd(ADDR_CTRL, v);
        chk("stop sent", 8'h65, v);
        chk("lines freed", 8'h03, {6'h0, scl_oe_n_o, sda_oe_n_o});
        wr(ADDR_CTRL, 8'h24);
    endtask

    // slave told to idle inside a frame: no flag for the bit or the stop
    task automatic t_idle_slave();
        wr(ADDR_CTRL, 8'h40);
        u_sbw_bus_peer.start();
        wr(ADDR_CTRL, 8'h40);
        u_sbw_bus_peer.send_bit(1'b1);
        rd(ADDR_CTRL, v);
        chk("idle slave ignores bus", 8'h01, v & 8'h7f);
        u_sbw_bus_peer.stop();
        rd(ADDR_CTRL, v);
        chk("idle slave ignores stop", 8'h01, v & 8'h7f);
    endtask

    // stall the frame after a bit and let the watchdog fire
    task automatic t_watchdog();
        int n;
        u_sbw_bus_peer.start();
        u_sbw_bus_peer.send_bit(1'b0);
        repeat (990) @(posedge clk_i);
        #1 chk("still stretched", 8'h00, {7'h0, scl_oe_n_o});
        n = 0;
        while (scl_oe_n_o !== 1'b1 && n < 60) begin
            @(posedge clk_i);
            #1 n++;
        end
        chk("watchdog frees clock", 8'h01, {7'h0, scl_oe_n_o});
        rd(ADDR_CTRL, v);
        chk("watchdog clears flags", 8'h01, v & 8'h7f);
        u_sbw_bus_peer.stop();
    endtask

    initial begin
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_bit_zero();
        t_bit_one();
        t_frames();
        t_master();
        t_idle_slave();
        t_watchdog();
        stop_test();
    end
endmodule
`default_nettype wire
